// >>> design/spx_serial_port.sv
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "spx_serial_port_cfg.svh"
module spx_serial_port (
  // Clock and reset.
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]                awaddr,
  input  wire logic                      awvalid,
  output wire logic                      awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output wire logic                      wready,
  output logic      [1:0]                bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]                araddr,
  input  wire logic                      arvalid,
  output wire logic                      arready,
  output logic      [31:0]               rdata,
  output logic      [1:0]                rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Serial pins.
  input  wire logic                      rxd_i,
  input  wire logic                      sck_i,
  output logic                           txd_o,
  output logic                           txd_oe_n,
  // Interrupt requests.
  output wire logic                      rx_full_interrupt,
  output wire logic                      rx_error_interrupt
);
  import spx_pkg::*;

  logic [6:0]       ctrl_r;
  logic [15:0]      baud_r;
  logic [7:0]       tx_hold_r;
  logic [7:0]       rx_buf_r;
  spx_flags_type    flags_r;
  spx_flags_type    flags_nxt;
  logic [1:0]       rxd_sync_r;
  logic [2:0]       sck_sync_r;
  logic [15:0]      div_cnt_r;
  spx_tx_state_type tx_state_r;
  spx_tx_state_type tx_state_nxt;
  logic [8:0]       tx_shift_r;
  logic [8:0]       tx_shift_nxt;
  logic [3:0]       tx_bit_r;
  logic [3:0]       tx_bit_nxt;
  logic [3:0]       tx_tick_r;
  logic             txd_r;
  logic             txd_nxt;
  spx_rx_state_type rx_state_r;
  spx_rx_state_type rx_state_nxt;
  logic [8:0]       rx_shift_r;
  logic [3:0]       rx_bit_r;
  logic [3:0]       rx_bit_nxt;
  logic [3:0]       rx_tick_r;
  logic             rx_done;
  logic             rx_fer;
  logic             rx_per;

  // Bus decode.
  wire       wr_go      = awvalid & wvalid & ~bvalid;
  wire       wr_lo      = wr_go & wstrb[0];
  wire       wr_ctrl    = wr_lo & (awaddr == `SPX_ADDR_CTRL);
  wire       wr_status  = wr_lo & (awaddr == `SPX_ADDR_STATUS);
  wire       wr_txdata  = wr_lo & (awaddr == `SPX_ADDR_TXDATA);
  wire       wr_baud    = wr_go & (awaddr == `SPX_ADDR_BAUD);
  wire       wr_hit     = (awaddr == `SPX_ADDR_CTRL) | (awaddr == `SPX_ADDR_STATUS) |
                          (awaddr == `SPX_ADDR_TXDATA) | (awaddr == `SPX_ADDR_RXDATA) |
                          (awaddr == `SPX_ADDR_BAUD);
  wire       rd_go      = arvalid & ~rvalid;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign arready = ~rvalid;

  // Controls and synchronised pins.
  wire       te         = ctrl_r[`SPX_CTRL_TE];
  wire       re         = ctrl_r[`SPX_CTRL_RE];
  wire       clkd       = ctrl_r[`SPX_CTRL_CLKD];
  wire       pen        = ctrl_r[`SPX_CTRL_PEN] & ~clkd;
  wire       podd       = ctrl_r[`SPX_CTRL_PODD];
  wire       rxd        = rxd_sync_r[1];
  wire       sck_rise   = sck_sync_r[1] & ~sck_sync_r[2];
  wire       sck_fall   = ~sck_sync_r[1] & sck_sync_r[2];
  wire       err_any    = flags_r.overrun_error_flag | flags_r.framing_error_flag | flags_r.per;
  wire [3:0] last_bit   = pen ? `SPX_BITS_9 : `SPX_BITS_8;
  wire       tick       = (div_cnt_r == baud_r);

  // Transmitter.
  wire       tx_load    = te & (tx_state_r == SPX_TX_IDLE) & ~flags_r.tx_buffer_empty_flag &
                          ~(clkd & err_any);
  // In clocked mode the frame closes on the rise that follows the last bit.
  wire       tx_last    = (tx_state_r == SPX_TX_DATA) & (tx_bit_r == last_bit);
  wire       tx_step    = clkd ? (sck_fall | (sck_rise & tx_last)) :
                          (tick & (tx_tick_r == `SPX_TICK_LAST));

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_shift_nxt = tx_shift_r;
    tx_bit_nxt   = tx_bit_r;
    txd_nxt      = txd_r;
    if (!te) begin
      tx_state_nxt = SPX_TX_IDLE;
      txd_nxt      = 1'b1;
    end else if (tx_load) begin
      tx_state_nxt = SPX_TX_START;
      tx_shift_nxt = {^tx_hold_r ^ podd, tx_hold_r};
      txd_nxt      = clkd ? txd_r : 1'b0;
    end else if (tx_step) begin
      unique case (tx_state_r)
        SPX_TX_IDLE: begin
        end
        SPX_TX_START: begin
          tx_state_nxt = SPX_TX_DATA;
          tx_bit_nxt   = 4'h0;
          txd_nxt      = tx_shift_r[0];
        end
        SPX_TX_DATA: begin
          if (tx_bit_r == last_bit) begin
            tx_state_nxt = clkd ? SPX_TX_IDLE : SPX_TX_STOP;
            txd_nxt      = clkd ? txd_r : 1'b1;
          end else begin
            tx_shift_nxt = {1'b0, tx_shift_r[8:1]};
            tx_bit_nxt   = tx_bit_r + 4'h1;
            txd_nxt      = tx_shift_r[1];
          end
        end
        SPX_TX_STOP: begin
          tx_state_nxt = SPX_TX_IDLE;
        end
      endcase
    end
  end

  // Receiver.
  wire       rx_sample  = tick & (rx_tick_r == `SPX_TICK_MID);
  wire       rx_clk_in  = re & clkd & ~err_any & sck_rise;
  wire [7:0] rx_data    = pen ? rx_shift_r[7:0] : rx_shift_r[8:1];
  wire [8:0] rx_shift_in = {rxd, rx_shift_r[8:1]};

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_bit_nxt   = rx_bit_r;
    rx_done      = 1'b0;
    rx_fer       = 1'b0;
    rx_per       = 1'b0;
    if (!re) begin
      rx_state_nxt = SPX_RX_IDLE;
    end else if (clkd) begin
      if (rx_clk_in) begin
        rx_bit_nxt   = rx_bit_r + 4'h1;
        rx_state_nxt = SPX_RX_DATA;
        if (rx_bit_r == `SPX_BITS_8) begin
          rx_done      = 1'b1;
          rx_bit_nxt   = 4'h0;
          rx_state_nxt = SPX_RX_IDLE;
        end
      end
    end else begin
      unique case (rx_state_r)
        SPX_RX_IDLE: begin
          if (!rxd) begin
            rx_state_nxt = SPX_RX_START;
          end
        end
        SPX_RX_START: begin
          if (rx_sample) begin
            rx_state_nxt = rxd ? SPX_RX_IDLE : SPX_RX_DATA;
            rx_bit_nxt   = 4'h0;
          end
        end
        SPX_RX_DATA: begin
          if (rx_sample) begin
            rx_bit_nxt   = rx_bit_r + 4'h1;
            if (rx_bit_r == last_bit) begin
              rx_state_nxt = SPX_RX_STOP;
            end
          end
        end
        SPX_RX_STOP: begin
          if (rx_sample) begin
            rx_done      = 1'b1;
            rx_fer       = ~rxd;
            rx_per       = pen & (^rx_shift_r ^ podd);
            rx_state_nxt = SPX_RX_IDLE;
          end
        end
      endcase
    end
  end

  wire       rx_shift_en = clkd ? rx_clk_in : (rx_sample & (rx_state_r == SPX_RX_DATA));
  wire       rx_ovr      = rx_done & flags_r.rx_full_flag;
  wire       rx_bad      = rx_fer | rx_per;

  // Status flags: hardware set wins over a software clear.
  wire [7:0] st_clr  = wr_status ? ~wdata[7:0] : 8'h00;
  always_comb begin
    flags_nxt.tx_buffer_empty_flag = (flags_r.tx_buffer_empty_flag & ~st_clr[`SPX_ST_TX_BUFFER_EMPTY_FLAG]) | tx_load | ~te;
    flags_nxt.rx_full_flag = (flags_r.rx_full_flag & ~st_clr[`SPX_ST_RX_FULL_FLAG]) |
                     (rx_done & ~rx_bad) | rx_ovr;
    flags_nxt.overrun_error_flag = (flags_r.overrun_error_flag & ~st_clr[`SPX_ST_OVERRUN_ERROR_FLAG]) | rx_ovr;
    flags_nxt.framing_error_flag  = (flags_r.framing_error_flag & ~st_clr[`SPX_ST_FER]) | rx_fer;
    flags_nxt.per  = (flags_r.per & ~st_clr[`SPX_ST_PER]) | rx_per;
    flags_nxt.tend = (flags_r.tend & ~tx_load) |
                     (tx_step & (tx_state_nxt == SPX_TX_IDLE) & (tx_state_r != SPX_TX_IDLE));
  end

  assign rx_full_interrupt  = flags_r.rx_full_flag;
  assign rx_error_interrupt = err_any;

  // Read data selection; the synchronised receive pin is visible for break checks.
  wire [7:0] status_rd = {flags_r.tx_buffer_empty_flag, flags_r.rx_full_flag, flags_r.overrun_error_flag, flags_r.framing_error_flag,
                          flags_r.per, flags_r.tend, 1'b0, rxd};
  wire       rd_hit    = (araddr == `SPX_ADDR_CTRL) | (araddr == `SPX_ADDR_STATUS) |
                         (araddr == `SPX_ADDR_TXDATA) | (araddr == `SPX_ADDR_RXDATA) |
                         (araddr == `SPX_ADDR_BAUD);
  wire [31:0] rd_val   = (araddr == `SPX_ADDR_CTRL)   ? {25'h0000000, ctrl_r} :
                         (araddr == `SPX_ADDR_STATUS) ? {24'h000000, status_rd} :
                         (araddr == `SPX_ADDR_TXDATA) ? {24'h000000, tx_hold_r} :
                         (araddr == `SPX_ADDR_RXDATA) ? {24'h000000, rx_buf_r} :
                         (araddr == `SPX_ADDR_BAUD)   ? {16'h0000, baud_r} : 32'h00000000;

  // Pin drive: with transmit disabled the pin is a general port.
  wire       pin_nxt   = te ? txd_nxt : ctrl_r[`SPX_CTRL_PDR];
  wire       oe_n_nxt  = te ? 1'b0 : ~ctrl_r[`SPX_CTRL_PDDR];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `SPX_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? `SPX_RESP_OKAY : `SPX_RESP_SLV;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `SPX_RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= rd_hit ? `SPX_RESP_OKAY : `SPX_RESP_SLV;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= `SPX_CTRL_RST;
      baud_r    <= `SPX_BAUD_RST;
      tx_hold_r <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata[6:0];
      if (wr_baud && wstrb[0]) baud_r[7:0] <= wdata[7:0];
      if (wr_baud && wstrb[1]) baud_r[15:8] <= wdata[15:8];
      if (wr_txdata) tx_hold_r <= wdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_sync_r <= 2'h3;
      sck_sync_r <= 3'h7;
      div_cnt_r  <= 16'h0000;
      flags_r    <= '{tx_buffer_empty_flag: 1'b1, default: 1'b0};
      tx_state_r <= SPX_TX_IDLE;
      tx_shift_r <= 9'h000;
      tx_bit_r   <= 4'h0;
      tx_tick_r  <= 4'h0;
      txd_r      <= 1'b1;
      txd_o      <= 1'b0;
      txd_oe_n   <= 1'b1;
      rx_state_r <= SPX_RX_IDLE;
      rx_shift_r <= 9'h000;
      rx_bit_r   <= 4'h0;
      rx_tick_r  <= 4'h0;
      rx_buf_r   <= 8'h00;
    end else begin
      rxd_sync_r <= {rxd_sync_r[0], rxd_i};
      sck_sync_r <= {sck_sync_r[1:0], sck_i};
      div_cnt_r  <= tick ? 16'h0000 : div_cnt_r + 16'h0001;
      flags_r    <= flags_nxt;
      tx_state_r <= tx_state_nxt;
      tx_shift_r <= tx_shift_nxt;
      tx_bit_r   <= tx_bit_nxt;
      tx_tick_r  <= tx_load ? 4'h0 : (tick ? tx_tick_r + 4'h1 : tx_tick_r);
      txd_r      <= txd_nxt;
      txd_o      <= pin_nxt;
      txd_oe_n   <= oe_n_nxt;
      rx_state_r <= rx_state_nxt;
      rx_bit_r   <= rx_bit_nxt;
      rx_tick_r  <= (rx_state_r == SPX_RX_IDLE) ? 4'h0 : (tick ? rx_tick_r + 4'h1 : rx_tick_r);
      if (rx_shift_en) rx_shift_r <= rx_shift_in;
      if (rx_done && !rx_ovr) rx_buf_r <= rx_data;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_tx_buffer_empty_flag_on_load;
    tx_load |=> flags_r.tx_buffer_empty_flag && tx_state_r == SPX_TX_START;
  endproperty
  a_tx_buffer_empty_flag_on_load: assert property (p_tx_buffer_empty_flag_on_load) else $error("empty flag not set on load");

  property p_hold_overwrite;
    wr_txdata |=> tx_hold_r == $past(wdata[7:0]);
  endproperty
  a_hold_overwrite: assert property (p_hold_overwrite) else $error("holding write lost");

  property p_overrun;
    rx_done && flags_r.rx_full_flag |=> flags_r.overrun_error_flag && flags_r.rx_full_flag && rx_buf_r == $past(rx_buf_r);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun handling wrong");

  property p_err_copy;
    rx_done && !flags_r.rx_full_flag && (rx_fer || rx_per) |=>
      rx_buf_r == $past(rx_data) && !flags_r.rx_full_flag;
  endproperty
  a_err_copy: assert property (p_err_copy) else $error("error byte not copied");

  property p_pin_port;
    !te ##1 !te |-> txd_o == $past(ctrl_r[`SPX_CTRL_PDR]) &&
                    txd_oe_n == !$past(ctrl_r[`SPX_CTRL_PDDR]);
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin not following port bits");

  property p_te_clear_init;
    $fell(te) |=> tx_state_r == SPX_TX_IDLE && flags_r.tx_buffer_empty_flag;
  endproperty
  a_te_clear_init: assert property (p_te_clear_init) else $error("transmitter not reset");

  property p_no_tx_on_err;
    clkd && err_any && tx_state_r == SPX_TX_IDLE |=> tx_state_r == SPX_TX_IDLE;
  endproperty
  a_no_tx_on_err: assert property (p_no_tx_on_err) else $error("transmit began with errors");

  property p_re_keeps_flags;
    $fell(re) && !$past(wr_status) |->
      ({flags_r.overrun_error_flag, flags_r.framing_error_flag, flags_r.per} &
       $past({flags_r.overrun_error_flag, flags_r.framing_error_flag, flags_r.per})) ==
      $past({flags_r.overrun_error_flag, flags_r.framing_error_flag, flags_r.per});
  endproperty
  a_re_keeps_flags: assert property (p_re_keeps_flags) else $error("flags lost on disable");

  property p_err_request;
    rx_done && rx_fer |=> rx_error_interrupt && flags_r.framing_error_flag;
  endproperty
  a_err_request: assert property (p_err_request) else $error("error request missing");
endmodule

// >>> design/spx_serial_port_cfg.svh
`ifndef SPX_SERIAL_PORT_CFG_SVH
`define SPX_SERIAL_PORT_CFG_SVH

`define SPX_ADDR_CTRL   8'h00
`define SPX_ADDR_STATUS 8'h04
`define SPX_ADDR_TXDATA 8'h08
`define SPX_ADDR_RXDATA 8'h0C
`define SPX_ADDR_BAUD   8'h10

`define SPX_CTRL_TE   0
`define SPX_CTRL_RE   1
`define SPX_CTRL_CLKD 2
`define SPX_CTRL_PDR  3
`define SPX_CTRL_PDDR 4
`define SPX_CTRL_PEN  5
`define SPX_CTRL_PODD 6
`define SPX_CTRL_RST  7'h00

`define SPX_ST_TX_BUFFER_EMPTY_FLAG  7
`define SPX_ST_RX_FULL_FLAG  6
`define SPX_ST_OVERRUN_ERROR_FLAG  5
`define SPX_ST_FER   4
`define SPX_ST_PER   3
`define SPX_ST_TEND  2
`define SPX_ST_RXPIN 0

`define SPX_BAUD_RST  16'h0000
`define SPX_TICK_LAST 4'hF
`define SPX_TICK_MID  4'h7
`define SPX_BITS_8    4'h7
`define SPX_BITS_9    4'h8
`define SPX_RESP_OKAY 2'h0
`define SPX_RESP_SLV  2'h2

`endif

// >>> design/spx_pkg.sv
package spx_pkg;
  typedef enum logic [1:0] {
    SPX_TX_IDLE  = 2'h0,
    SPX_TX_START = 2'h1,
    SPX_TX_DATA  = 2'h3,
    SPX_TX_STOP  = 2'h2
  } spx_tx_state_type;

  typedef enum logic [1:0] {
    SPX_RX_IDLE  = 2'h0,
    SPX_RX_START = 2'h1,
    SPX_RX_DATA  = 2'h3,
    SPX_RX_STOP  = 2'h2
  } spx_rx_state_type;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic rx_full_flag;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic per;
    logic tend;
  } spx_flags_type;
endpackage

// >>> dv/spx_remote_peer.sv
`timescale 1ns/1ps
module spx_remote_peer #(
  parameter int  BIT_NS = 640,
  parameter real SCK_HALF_NS = 62.5
) (
  // Lines towards the device.
  output logic      rxd,
  output logic      sck,
  input  wire logic txd
);
  // The line idles at mark and the serial clock stands high between frames.
  initial begin
    rxd = 1'b1;
    sck = 1'b1;
  end

  // Line changes are non-blocking, so they never race the device's sampling edge.
  task automatic send(input logic [7:0] b, input logic par_en, bad_par, bad_stop);
    rxd <= 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      #(BIT_NS);
    end
    if (par_en) begin
      rxd <= ^b ^ bad_par;
      #(BIT_NS);
    end
    rxd <= ~bad_stop;
    #(BIT_NS);
    rxd <= 1'b1;
  endtask

  task automatic hold_break(input int bits);
    rxd <= 1'b0;
    #(bits * BIT_NS);
    rxd <= 1'b1;
  endtask

  // Samples an asynchronous frame from the device at the middle of each bit.
  task automatic catch_frame(output logic [7:0] b, output logic stop);
    @(negedge txd);
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      b[i] = txd;
    end
    #(BIT_NS);
    stop = txd;
  endtask

  // Clocks eight bits out of the device in clocked mode.
  task automatic clk_frame(output logic [7:0] b);
    #100;
    for (int i = 0; i < 8; i++) begin
      sck <= 1'b0;
      #(SCK_HALF_NS);
      sck <= 1'b1;
      b[i] = txd;
      #(SCK_HALF_NS);
    end
  endtask
endmodule

// >>> dv/test_serial_port_tx_rx_status.sv
`timescale 1ns/1ps
`include "spx_serial_port_cfg.svh"
module test_serial_port_tx_rx_status;
  localparam int BIT_NS = 640;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rxd, sck, txd_o, txd_oe_n;
  logic        irq_full, irq_err, s1, s2;
  logic [7:0]  awaddr, araddr, b1, b2;
  logic [31:0] wdata, rdata, rd_val, exp;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb;
  int          error_cnt, total_checks, cyc;

  spx_serial_port dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxd_i(rxd), .sck_i(sck),
    .txd_o(txd_o), .txd_oe_n(txd_oe_n), .rx_full_interrupt(irq_full),
    .rx_error_interrupt(irq_err)
  );

  spx_remote_peer #(.BIT_NS(BIT_NS)) peer (.rxd(rxd), .sck(sck), .txd(txd_o));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string n);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, want, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    @(negedge aclk);
    while (!awready) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    @(negedge aclk);
    while (!bvalid) @(negedge aclk);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e, input string n);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    rd_val = rdata;
    resp   = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    chk(rd_val & m, e, n);
  endtask

  task automatic pins(input logic lvl, input logic oe_n);
    repeat (2) @(negedge aclk);
    chk({31'h0, txd_o}, {31'h0, lvl}, "pin level");
    chk({31'h0, txd_oe_n}, {31'h0, oe_n}, "pin enable");
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    error_cnt = 0;
    total_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`SPX_ADDR_STATUS, 32'h000000FF, 32'h00000081, "status after reset");
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h00000000, "unmapped read data");
    chk({30'h0, resp}, 32'h00000002, "unmapped read response");
    wr(8'h20, 32'h00000000);
    chk({30'h0, resp}, 32'h00000002, "unmapped write response");
    wr(`SPX_ADDR_BAUD, 32'h00000003);
    wr(`SPX_ADDR_CTRL, 32'h00000018);
    pins(1'b1, 1'b0);
    wr(`SPX_ADDR_CTRL, 32'h00000019);
    wr(`SPX_ADDR_TXDATA, 32'h000000A5);
    fork
      begin
        peer.catch_frame(b1, s1);
        peer.catch_frame(b2, s2);
      end
      begin
        wr(`SPX_ADDR_STATUS, 32'h0000007F);
        rd_chk(`SPX_ADDR_STATUS, 32'h00000080, 32'h00000080, "empty after load");
        wr(`SPX_ADDR_TXDATA, 32'h00000011);
        wr(`SPX_ADDR_STATUS, 32'h0000007F);
        wr(`SPX_ADDR_TXDATA, 32'h00000022);
      end
    join
    chk({24'h0, b1}, 32'h000000A5, "first frame");
    chk({31'h0, s1}, 32'h00000001, "first stop bit");
    chk({24'h0, b2}, 32'h00000022, "overwritten frame");
    wr(`SPX_ADDR_TXDATA, 32'h000000FF);
    wr(`SPX_ADDR_STATUS, 32'h0000007F);
    repeat (100) @(posedge aclk);
    wr(`SPX_ADDR_CTRL, 32'h00000011);
    wr(`SPX_ADDR_CTRL, 32'h00000010);
    pins(1'b0, 1'b0);
    rd_chk(`SPX_ADDR_STATUS, 32'h00000080, 32'h00000080, "empty after disable");
    wr(`SPX_ADDR_CTRL, 32'h00000008);
    repeat (2) @(negedge aclk);
    chk({31'h0, txd_oe_n}, 32'h00000001, "pin released");
    wr(`SPX_ADDR_CTRL, 32'h0000003A);
    for (int k = 0; k < 8; k++) begin
      wr(`SPX_ADDR_STATUS, 32'h00000087);
      if (k[2]) peer.send(8'h3C, 1'b1, 1'b0, 1'b0);
      peer.send(8'h50 | k[7:0], 1'b1, k[0], k[1]);
      exp = {25'h0, k[2] | ~(k[1] | k[0]), k[2:0], 3'h0};
      rd_chk(`SPX_ADDR_STATUS, 32'h00000078, exp, "receive flags");
      rd_chk(`SPX_ADDR_RXDATA, 32'h000000FF, k[2] ? 32'h3C : 32'h50 | k, "rx buffer");
      @(negedge aclk);
      chk({31'h0, irq_err}, {31'h0, |k[2:0]}, "error request");
      chk({31'h0, irq_full}, {31'h0, exp[6]}, "full request");
      #(13 * BIT_NS);
    end
    wr(`SPX_ADDR_CTRL, 32'h00000038);
    rd_chk(`SPX_ADDR_STATUS, 32'h00000038, 32'h00000038, "errors kept");
    wr(`SPX_ADDR_CTRL, 32'h0000003A);
    wr(`SPX_ADDR_STATUS, 32'h00000087);
    fork
      peer.hold_break(40);
      begin
        #(12 * BIT_NS);
        rd_chk(`SPX_ADDR_STATUS, 32'h00000011, 32'h00000010, "break flag and pin");
        wr(`SPX_ADDR_STATUS, 32'h00000087);
        #(14 * BIT_NS);
        rd_chk(`SPX_ADDR_STATUS, 32'h00000010, 32'h00000010, "break flag again");
      end
    join
    #(13 * BIT_NS);
    wr(`SPX_ADDR_CTRL, 32'h0000001D);
    wr(`SPX_ADDR_TXDATA, 32'h00000096);
    wr(`SPX_ADDR_STATUS, 32'h0000007F);
    peer.clk_frame(b1);
    rd_chk(`SPX_ADDR_STATUS, 32'h00000090, 32'h00000010, "error held");
    chk({24'h0, b1}, 32'h000000FF, "blocked frame");
    wr(`SPX_ADDR_STATUS, 32'h00000087);
    peer.clk_frame(b2);
    chk({24'h0, b2}, 32'h00000096, "clocked frame");
    report_and_stop();
  end
endmodule
